// ==== program_flash_read_port.sv ====
// Program-memory read port with AXI4-Lite registers and slot discard.
// Assumes the core runs one instruction per divider enable and obeys
// the discard output for the slot in which the memory is busy.
//
// How it works
// - Memory access occurs in second instruction cycle.
// - Second slot discarded, first slot executes normally.
// - Word lands in data registers next cycle.
// - Data registers hold until read or write.
// - Write strobe with program space clears, nothing happens.
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`default_nettype none

module program_flash_read_port #(
    parameter int unsigned PM_AW = 11,
    parameter int unsigned WORD_W = 14,
    parameter int unsigned DIV = flash_read_pkg::CLK_PER_INSTR
) (
    // Clock and reset
    input  wire logic                                 aclk,
    input  wire logic                                 aresetn,
    // AXI4-Lite write address
    input  wire logic [flash_read_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                                 s_axi_awvalid,
    output var  logic                                 s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]                          s_axi_wdata,
    input  wire logic [3:0]                           s_axi_wstrb,
    input  wire logic                                 s_axi_wvalid,
    output var  logic                                 s_axi_wready,
    // AXI4-Lite write response
    output var  logic [1:0]                           s_axi_bresp,
    output var  logic                                 s_axi_bvalid,
    input  wire logic                                 s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [flash_read_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                                 s_axi_arvalid,
    output var  logic                                 s_axi_arready,
    // AXI4-Lite read data
    output var  logic [31:0]                          s_axi_rdata,
    output var  logic [1:0]                           s_axi_rresp,
    output var  logic                                 s_axi_rvalid,
    input  wire logic                                 s_axi_rready,
    // Program word loader
    input  wire logic                                 load_en,
    input  wire logic [PM_AW-1:0]                     load_addr,
    input  wire logic [WORD_W-1:0]                    load_word,
    // Core side
    output var  logic                                 slot_discard,
    output var  logic                                 read_busy
);
    import flash_read_pkg::*;

    localparam int unsigned HI_W = WORD_W - 8;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]            addr_lo;
        logic [7:0]            addr_hi;
        logic                  pss;
        logic                  rd;
        logic                  wr;
        logic [7:0]            dat_lo;
        logic [HI_W-1:0]       dat_hi;
        seq_e                  st;
        logic                  discard;
        logic                  busy;
        logic                  aw_got;
        logic [AXI_ADDR_W-1:0] awaddr;
        logic                  w_got;
        logic [7:0]            wdata;
        logic                  wstrb0;
        logic                  awready;
        logic                  wready;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  arready;
        logic                  rvalid;
        logic [31:0]           rdata;
        logic [1:0]            rresp;
    } state_s;

    state_s s_r;
    state_s s_nxt;

    logic              ce;
    logic [WORD_W-1:0] mem_q;
    logic [15:0]       full_addr;
    logic              wr_commit;
    logic              latch_now;
    sel_e              wsel;

    function automatic sel_e reg_sel(input logic [AXI_ADDR_W-1:0] a);
        sel_e r;
        r = SEL_NONE;
        case ({a[AXI_ADDR_W-1:2], 2'h0})
            OFS_ADDR_LOW:  r = SEL_ALO;
            OFS_ADDR_HIGH: r = SEL_AHI;
            OFS_CONTROL:   r = SEL_CTRL;
            OFS_DATA_LOW:  r = SEL_DLO;
            OFS_DATA_HIGH: r = SEL_DHI;
            default:       r = SEL_NONE;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    instr_cycle_divider #(.DIV(DIV)) u_div (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce_r    (ce)
    );

    assign full_addr = {s_r.addr_hi, s_r.addr_lo};

    program_word_array #(.AW(PM_AW), .DW(WORD_W)) u_mem (
        .aclk      (aclk),
        .load_en   (load_en),
        .load_addr (load_addr),
        .load_word (load_word),
        .rd_addr   (full_addr[PM_AW-1:0]),
        .rd_word   (mem_q)
    );

    assign wr_commit = s_r.aw_got && s_r.w_got && !s_r.bvalid;
    assign wsel      = reg_sel(s_r.awaddr);
    assign latch_now = (s_r.st == SEQ_ACCESS) && ce;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        // Bus capture; address and data may arrive in either order
        if (s_axi_awvalid && s_r.awready) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_r.wready) begin
            s_nxt.w_got  = 1'b1;
            s_nxt.wdata  = s_axi_wdata[7:0];
            s_nxt.wstrb0 = s_axi_wstrb[0];
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end

        // Read sequence, one step per instruction cycle
        case (s_r.st)
            SEQ_IDLE: begin
                if (s_r.rd && ce) begin
                    s_nxt.st = SEQ_SLOT1;
                end
            end
            SEQ_SLOT1: begin
                if (ce) begin
                    s_nxt.st      = SEQ_ACCESS;
                    s_nxt.discard = 1'b1;
                end
            end
            SEQ_ACCESS: begin
                if (ce) begin
                    s_nxt.st      = SEQ_IDLE;
                    s_nxt.discard = 1'b0;
                    s_nxt.dat_lo  = mem_q[7:0];
                    s_nxt.dat_hi  = mem_q[WORD_W-1:8];
                    s_nxt.rd      = 1'b0;
                end
            end
            default: begin
                s_nxt.st      = SEQ_IDLE;
                s_nxt.discard = 1'b0;
            end
        endcase

        // Register writes; a latching read wins over a data write
        if (wr_commit) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got  = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp  = RESP_OKAY;
            case (wsel)
                SEL_ALO: begin
                    if (s_r.wstrb0) begin
                        s_nxt.addr_lo = s_r.wdata;
                    end
                end
                SEL_AHI: begin
                    if (s_r.wstrb0) begin
                        s_nxt.addr_hi = s_r.wdata;
                    end
                end
                SEL_CTRL: begin
                    if (s_r.wstrb0) begin
                        s_nxt.pss = s_r.wdata[CTRL_PSS_BIT];
                        s_nxt.wr  = s_r.wdata[CTRL_WR_BIT] && !s_r.wdata[CTRL_PSS_BIT];
                        if (s_r.st == SEQ_IDLE && !s_r.rd && s_r.wdata[CTRL_RD_BIT]
                            && s_r.wdata[CTRL_PSS_BIT]) begin
                            s_nxt.rd = 1'b1;
                        end
                    end
                end
                SEL_DLO: begin
                    if (s_r.wstrb0 && !latch_now) begin
                        s_nxt.dat_lo = s_r.wdata;
                    end
                end
                SEL_DHI: begin
                    if (s_r.wstrb0 && !latch_now) begin
                        s_nxt.dat_hi = s_r.wdata[HI_W-1:0];
                    end
                end
                default: begin
                    s_nxt.bresp = RESP_SLVERR;
                end
            endcase
        end

        // Register reads return the value at the address handshake
        if (s_axi_arvalid && s_r.arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp  = RESP_OKAY;
            s_nxt.rdata  = 32'h0;
            case (reg_sel(s_axi_araddr))
                SEL_ALO:  s_nxt.rdata[7:0] = s_r.addr_lo;
                SEL_AHI:  s_nxt.rdata[7:0] = s_r.addr_hi;
                SEL_CTRL: begin
                    s_nxt.rdata[CTRL_PSS_BIT] = s_r.pss;
                    s_nxt.rdata[CTRL_WR_BIT]  = s_r.wr;
                    s_nxt.rdata[CTRL_RD_BIT]  = s_r.rd;
                end
                SEL_DLO:  s_nxt.rdata[7:0] = s_r.dat_lo;
                SEL_DHI:  s_nxt.rdata[HI_W-1:0] = s_r.dat_hi;
                default:  s_nxt.rresp = RESP_SLVERR;
            endcase
        end

        s_nxt.busy    = s_nxt.rd;
        s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
        s_nxt.wready  = !s_nxt.w_got && !s_nxt.bvalid;
        s_nxt.arready = !s_nxt.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign s_axi_awready = s_r.awready;
    assign s_axi_wready  = s_r.wready;
    assign s_axi_bresp   = s_r.bresp;
    assign s_axi_bvalid  = s_r.bvalid;
    assign s_axi_arready = s_r.arready;
    assign s_axi_rdata   = s_r.rdata;
    assign s_axi_rresp   = s_r.rresp;
    assign s_axi_rvalid  = s_r.rvalid;
    assign slot_discard  = s_r.discard;
    assign read_busy     = s_r.busy;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    localparam int SLOT_MAX = 16;

    logic ctrl_pss_write;
    logic dlo_write;
    assign ctrl_pss_write = wr_commit && wsel == SEL_CTRL && s_r.wstrb0
                            && s_r.wdata[CTRL_PSS_BIT];
    assign dlo_write = wr_commit && wsel == SEL_DLO && s_r.wstrb0;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_arm;
        s_r.st == SEQ_IDLE && s_r.rd && ce;
    endsequence

    sequence s_reach_access;
        (s_r.st == SEQ_SLOT1 && !s_r.discard) ##[1:SLOT_MAX]
        (s_r.st == SEQ_ACCESS && s_r.discard);
    endsequence

    a_access_second_slot: assert property (s_arm |=> s_reach_access)
        else $error("access not in second instruction cycle");

    a_discard_only_access: assert property (s_r.discard |-> s_r.st == SEQ_ACCESS)
        else $error("discard outside access slot");

    a_first_slot_runs: assert property ($rose(s_r.discard) |-> $past(s_r.st) == SEQ_SLOT1)
        else $error("discard did not follow first slot");

    a_word_latched: assert property (latch_now |=>
        s_r.dat_lo == $past(mem_q[7:0]) && s_r.dat_hi == $past(mem_q[WORD_W-1:8])
        && s_r.st == SEQ_IDLE && !s_r.discard)
        else $error("fetched word not latched");

    a_data_held: assert property (!latch_now && !dlo_write |=> $stable(s_r.dat_lo))
        else $error("read data changed without cause");

    a_write_refused: assert property (ctrl_pss_write |=> !s_r.wr)
        else $error("write strobe kept in program space");

    a_strobe_cleared: assert property (latch_now |=> !s_r.rd && !slot_discard)
        else $error("read strobe not cleared after latch");

    a_strobe_fall: assert property ($fell(s_r.rd) |-> $past(latch_now))
        else $error("read strobe cleared early");

endmodule

`default_nettype wire

// ==== flash_read_pkg.sv ====
// Shared constants for the program-memory read port.
// Assumes a 32-bit AXI4-Lite register bus with 8-bit byte addresses.
`default_nettype none

package flash_read_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam int unsigned AXI_ADDR_W = 8;
    localparam logic [7:0] OFS_ADDR_LOW  = 8'h00;
    localparam logic [7:0] OFS_ADDR_HIGH = 8'h04;
    localparam logic [7:0] OFS_CONTROL   = 8'h08;
    localparam logic [7:0] OFS_DATA_LOW  = 8'h0C;
    localparam logic [7:0] OFS_DATA_HIGH = 8'h10;

    // ------------------------------------------------------------
    // Control register fields and reset values
    // ------------------------------------------------------------
    localparam int unsigned CTRL_RD_BIT  = 0;
    localparam int unsigned CTRL_WR_BIT  = 1;
    localparam int unsigned CTRL_PSS_BIT = 7;
    localparam logic [7:0]  RST_BYTE     = 8'h00;

    // ------------------------------------------------------------
    // Timing and bus answers
    // ------------------------------------------------------------
    localparam int unsigned CLK_PER_INSTR = 4;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef enum logic [1:0] {
        SEQ_IDLE   = 2'b00,
        SEQ_SLOT1  = 2'b01,
        SEQ_ACCESS = 2'b10
    } seq_e;

    typedef enum logic [2:0] {
        SEL_NONE  = 3'b000,
        SEL_ALO   = 3'b001,
        SEL_AHI   = 3'b010,
        SEL_CTRL  = 3'b011,
        SEL_DLO   = 3'b100,
        SEL_DHI   = 3'b101
    } sel_e;

endpackage

`default_nettype wire

// ==== instr_cycle_divider.sv ====
// Divides the core clock into one-cycle instruction-cycle enables.
// Assumes a single clock and a synchronous active-low reset.
`default_nettype none

module instr_cycle_divider #(
    parameter int unsigned DIV = 4
) (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Enable out
    output var  logic ce_r
);
    import flash_read_pkg::*;

    localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= '0;
            ce_r  <= 1'b0;
        end else begin
            ce_r  <= (cnt_r == LAST);
            cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + CW'(1);
        end
    end

endmodule

`default_nettype wire

// ==== program_word_array.sv ====
// Program word storage with a registered read and a load port.
// Assumes the loader writes words before reads are issued.
`default_nettype none

module program_word_array #(
    parameter int unsigned AW = 11,
    parameter int unsigned DW = 14
) (
    // Clock
    input  wire logic          aclk,
    // Load port
    input  wire logic          load_en,
    input  wire logic [AW-1:0] load_addr,
    input  wire logic [DW-1:0] load_word,
    // Read port
    input  wire logic [AW-1:0] rd_addr,
    output var  logic [DW-1:0] rd_word
);
    import flash_read_pkg::*;

    logic [DW-1:0] mem [0:(1<<AW)-1];

    // Read every clock so the word is settled before the latch edge
    always_ff @(posedge aclk) begin
        if (load_en) begin
            mem[load_addr] <= load_word;
        end
        rd_word <= mem[rd_addr];
    end

endmodule

`default_nettype wire

// ==== core_slot_model.sv ====
// Core-side model that counts the clocks of discarded slots and of busy reads.
// Assumes one clock domain shared with the program read port.
`default_nettype none

module core_slot_model (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Slot status from the port
    input  wire logic slot_discard,
    input  wire logic read_busy,
    // Running counts
    output var  int   discard_cycles,
    output var  int   busy_cycles
);
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // The core ignores every clock of a discarded slot
    // ------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            discard_cycles <= 0;
            busy_cycles    <= 0;
        end else begin
            if (slot_discard === 1'b1) discard_cycles <= discard_cycles + 1;
            if (read_busy === 1'b1) busy_cycles <= busy_cycles + 1;
        end
    end
endmodule

`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the program-memory read port over AXI4-Lite.
// Assumes the port answers each bus request and flags slots for the core.
`default_nettype none

module testbench;
    import flash_read_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int DIV = 4;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, load_en;
    logic        awready, wready, bvalid, arready, rvalid, slot_discard, read_busy;
    logic [7:0]  awaddr, araddr;
    logic [3:0]  wstrb;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic [10:0] load_addr;
    logic [13:0] load_word;
    int          dcyc, bcyc, fail_count, samples_checked, seed, mem[int], pa_q[$];

    program_flash_read_port #(.PM_AW(11), .WORD_W(14), .DIV(DIV)) program_flash_read_port_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .load_en(load_en), .load_addr(load_addr), .load_word(load_word),
        .slot_discard(slot_discard), .read_busy(read_busy));

    core_slot_model core_slot_model_inst (
        .aclk(aclk), .aresetn(aresetn), .slot_discard(slot_discard), .read_busy(read_busy),
        .discard_cycles(dcyc), .busy_cycles(bcyc));

    initial aclk = 1'b0;
    always #12.5 aclk = ~aclk;

    // ------------------------------------------------------------
    // Compare and closing tasks
    // ------------------------------------------------------------
    task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("BAD t=%0t value %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk_rng(input int g, input int lo, input int hi);
        samples_checked++;
        if (g < lo || g > hi) begin
            fail_count++;
            $display("BAD t=%0t count %0d outside %0d..%0d", $time, g, lo, hi);
        end
    endtask

    task automatic conclude();
        if (fail_count == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // AXI4-Lite master
    // ------------------------------------------------------------
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
        forever begin
            @(posedge aclk);
            n++;
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
            if (n > 500) begin
                fail_count++;
                conclude();
            end
        end
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        forever begin
            @(posedge aclk);
            n++;
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
            if (n > 500) begin
                fail_count++;
                conclude();
            end
        end
    endtask

    // ------------------------------------------------------------
    // One program read, checked against the word model
    // ------------------------------------------------------------
    task automatic do_read(input int pa);
        logic [31:0] d;
        logic [1:0]  r;
        int          d0, b0, n, hi;
        hi = ($random(seed) & 32'hF8) | ((pa >> 8) & 7);
        axi_wr(OFS_ADDR_LOW, pa & 32'hFF, r);
        axi_wr(OFS_ADDR_HIGH, hi, r);
        axi_wr(OFS_CONTROL, 32'h80, r);
        d0 = dcyc;
        b0 = bcyc;
        axi_wr(OFS_CONTROL, 32'h81, r);
        chk_val(r, RESP_OKAY);
        n = 0;
        // No request while the two slots run
        while (read_busy !== 1'b0 && n < 200) begin
            @(posedge aclk);
            n++;
        end
        chk_rng(bcyc - b0, 2 * DIV + 1, 3 * DIV);
        chk_rng(dcyc - d0, DIV, DIV);
        axi_rd(OFS_DATA_LOW, d, r);
        chk_val(d, mem[pa] & 32'hFF);
        axi_rd(OFS_DATA_HIGH, d, r);
        chk_val(d, (mem[pa] >> 8) & 32'h3F);
        axi_rd(OFS_CONTROL, d, r);
        chk_val(d, 32'h80);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        logic [7:0]  regs [5];
        int          w;
        regs = '{OFS_ADDR_LOW, OFS_ADDR_HIGH, OFS_CONTROL, OFS_DATA_LOW, OFS_DATA_HIGH};
        {awvalid, wvalid, bready, arvalid, rready, load_en} = '0;
        awaddr = '0; araddr = '0; wdata = '0; load_addr = '0; load_word = '0;
        wstrb = 4'hF;
        aresetn = 1'b0;
        fail_count = 0; samples_checked = 0; seed = 3315;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        pa_q = '{0, 2047};
        repeat (4) pa_q.push_back($random(seed) & 32'h7FF);
        foreach (pa_q[i]) begin
            w = $random(seed) & 32'h3FFF;
            mem[pa_q[i]] = w;
            @(posedge aclk);
            load_en <= 1'b1; load_addr <= pa_q[i][10:0]; load_word <= w[13:0];
        end
        @(posedge aclk);
        load_en <= 1'b0;
        foreach (regs[i]) begin
            axi_rd(regs[i], d, r);
            chk_val(d, {24'h0, RST_BYTE});
        end
        axi_wr(8'h14, 32'h11, r);
        chk_val(r, RESP_SLVERR);
        axi_rd(8'h14, d, r);
        chk_val(r, RESP_SLVERR);
        foreach (pa_q[i]) do_read(pa_q[i]);
        w = mem[pa_q[pa_q.size() - 1]];
        axi_wr(OFS_ADDR_LOW, 32'h55, r);
        axi_wr(OFS_ADDR_HIGH, 32'h03, r);
        axi_rd(OFS_DATA_LOW, d, r);
        chk_val(d, w & 32'hFF);
        axi_wr(OFS_DATA_LOW, 32'hA5, r);
        axi_rd(OFS_DATA_LOW, d, r);
        chk_val(d, 32'hA5);
        axi_wr(OFS_DATA_HIGH, 32'hFF, r);
        axi_rd(OFS_DATA_HIGH, d, r);
        chk_val(d, 32'h3F);
        axi_wr(OFS_CONTROL, 32'h82, r);
        axi_rd(OFS_CONTROL, d, r);
        chk_val(d, 32'h80);
        chk_val({31'h0, read_busy}, 32'h0);
        axi_wr(OFS_CONTROL, 32'h02, r);
        axi_rd(OFS_CONTROL, d, r);
        chk_val(d, 32'h02);
        axi_wr(OFS_CONTROL, 32'h01, r);
        axi_rd(OFS_CONTROL, d, r);
        chk_val(d, 32'h00);
        // Masked byte lane: answered OKAY but nothing is stored
        wstrb <= 4'h0;
        axi_wr(OFS_DATA_LOW, 32'h11, r);
        wstrb <= 4'hF;
        chk_val(r, RESP_OKAY);
        axi_rd(OFS_DATA_LOW, d, r);
        chk_val(d, 32'hA5);
        conclude();
    end

    initial begin
        #(25 * 20000);
        fail_count++;
        conclude();
    end
endmodule

`default_nettype wire
